// ---- rtl/scp_regs.vh ----
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
// frame layout
`define SCP_RW_BIT 31
`define SCP_CODE_HI 30
`define SCP_CODE_LO 27
`define SCP_CH_HI 25
`define SCP_CH_LO 24
// register codes
`define SCP_CODE_INTLIM 4'h4
`define SCP_CODE_PERIOD 4'h5
`define SCP_CODE_THROL 4'h6
// channel codes
`define SCP_CH_FIRST 2'h1
`define SCP_CH_SECOND 2'h2
// integrator clamp limits
`define SCP_HILIM_HI 23
`define SCP_HILIM_LO 12
`define SCP_LOLIM_HI 11
`define SCP_LOLIM_LO 0
`define SCP_LIM_RESET 12'h7FF
`define SCP_LIM_SCALE_SHIFT 5
// period register: integral gain index and switching period
`define SCP_KI_HI 22
`define SCP_KI_LO 20
`define SCP_KI_RESET 3'h2
`define SCP_KI_MAX 3'h6
`define SCP_PER_HI 11
`define SCP_PER_LO 0
`define SCP_PER_RESET 12'h000
`define SCP_PER_TICKS 16
// threshold and open-load-on
`define SCP_THR_HI 21
`define SCP_THR_LO 6
`define SCP_THR_RESET 16'h0000
`define SCP_OL_HI 5
`define SCP_OL_LO 0
`define SCP_OL_RESET 6'h00
`endif

// ---- rtl/scp_chan.v ----
`timescale 1ns/1ps
`include "scp_regs.vh"
// one channel's parameter storage
module scp_chan (
   // clock and reset
   input wire CLK_SYS,
   input wire RST,
   // write strobes and data
   input wire wr_lim,
   input wire wr_per,
   input wire wr_thr,
   input wire [31:0] wdata,
   // turn-off threshold update from the period controller
   input wire thr_load,
   input wire [15:0] thr_value,
   // stored fields
   output reg [11:0] hi_lim_reg,
   output reg [11:0] lo_lim_reg,
   output reg [2:0] ki_idx_reg,
   output reg [11:0] period_reg,
   output reg [15:0] thr_reg,
   output reg [5:0] ol_reg
);
   wire [2:0] ki_in;
   wire [2:0] ki_next;
   assign ki_in = wdata[`SCP_KI_HI:`SCP_KI_LO];
   assign ki_next = (ki_in > `SCP_KI_MAX) ? `SCP_KI_MAX : ki_in;

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         hi_lim_reg <= `SCP_LIM_RESET;
         lo_lim_reg <= `SCP_LIM_RESET;
         ki_idx_reg <= `SCP_KI_RESET;
         period_reg <= `SCP_PER_RESET;
         thr_reg <= `SCP_THR_RESET;
         ol_reg <= `SCP_OL_RESET;
      end else begin
         if (wr_lim) begin
            hi_lim_reg <= wdata[`SCP_HILIM_HI:`SCP_HILIM_LO];
            lo_lim_reg <= wdata[`SCP_LOLIM_HI:`SCP_LOLIM_LO];
         end
         if (wr_per) begin
            ki_idx_reg <= ki_next;
            period_reg <= wdata[`SCP_PER_HI:`SCP_PER_LO];
         end
         if (wr_thr) begin
            ol_reg <= wdata[`SCP_OL_HI:`SCP_OL_LO];
         end
         // threshold only follows the controller, never the host write
         if (thr_load) begin
            thr_reg <= thr_value;
         end
      end
   end
endmodule // scp_chan

// ---- rtl/scp_tick.v ----
`timescale 1ns/1ps
// one-cycle enable every DIV cycles
module scp_tick #(
   parameter DIV = 16
) (
   // clock and reset
   input wire CLK_SYS,
   input wire RST,
   // enable pulse
   output reg tick
);
   reg [7:0] cnt_reg;
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cnt_reg <= 8'h00;
         tick <= 1'b0;
      end else if (cnt_reg == DIV - 1) begin
         cnt_reg <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule // scp_tick

// ---- rtl/scp_top.v ----
// Overview of operation
// - frame bit 31 set means write, clear means read; read data has it clear
// - frame bits 25:24 pick channel: 01 first, 10 second load channel
// - upper integrator clamp: 12 bits at 23:12, reset 7FF, applied as 32 times
// - lower integrator clamp: 12 bits at 11:0, reset 7FF, applied as minus 32 times
// - period controller integral gain is two to minus index in bits 22:20
// - gain index saturates at six; writing seven stores six
// - gain index resets to two, giving gain one quarter
// - switching period field bits 11:0, one count is 16 system clocks
// - bits 21:6 read turn-off threshold set by period controller, reset zero
// - host writes never change the turn-off threshold field
// - open-load-on threshold bits 5:0, reset zero, read-write
// - open-load-on detection stays off while its threshold is zero
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_top (
   // clock and reset
   input wire CLK_SYS,
   input wire RST,
   // register frame port, same clock domain as the frame decoder
   input wire FRAME_VALID,
   input wire [31:0] FRAME_DATA,
   output reg READ_VALID,
   output reg [31:0] READ_DATA,
   // per-channel turn-off threshold from the period controller
   input wire THR_LOAD_1,
   input wire THR_LOAD_2,
   input wire [15:0] THR_VALUE_1,
   input wire [15:0] THR_VALUE_2,
   // applied parameters, first load channel
   output reg signed [17:0] CLAMP_HI_1,
   output reg signed [17:0] CLAMP_LO_1,
   output reg [2:0] KI_SHIFT_1,
   output reg [15:0] PERIOD_CLKS_1,
   output reg OL_ON_EN_1,
   output reg [5:0] OL_ON_LIMIT_1,
   // applied parameters, second load channel
   output reg signed [17:0] CLAMP_HI_2,
   output reg signed [17:0] CLAMP_LO_2,
   output reg [2:0] KI_SHIFT_2,
   output reg [15:0] PERIOD_CLKS_2,
   output reg OL_ON_EN_2,
   output reg [5:0] OL_ON_LIMIT_2,
   // 16-cycle enable that paces the period count
   output reg PERIOD_TICK
);
   // ****************************************
   // frame decode
   // ****************************************
   wire is_write;
   wire [3:0] code;
   wire [1:0] chan;
   wire sel1;
   wire sel2;
   wire hit_lim;
   wire hit_per;
   wire hit_thr;
   assign is_write = FRAME_DATA[`SCP_RW_BIT];
   assign code = FRAME_DATA[`SCP_CODE_HI:`SCP_CODE_LO];
   assign chan = FRAME_DATA[`SCP_CH_HI:`SCP_CH_LO];
   assign sel1 = (chan == `SCP_CH_FIRST);
   assign sel2 = (chan == `SCP_CH_SECOND);
   assign hit_lim = (code == `SCP_CODE_INTLIM);
   assign hit_per = (code == `SCP_CODE_PERIOD);
   assign hit_thr = (code == `SCP_CODE_THROL);

   wire wr_ok;
   assign wr_ok = FRAME_VALID & is_write;

   // ****************************************
   // channel storage
   // ****************************************
   wire [11:0] hi1;
   wire [11:0] lo1;
   wire [2:0] ki1;
   wire [11:0] per1;
   wire [15:0] thr1;
   wire [5:0] ol1;
   wire [11:0] hi2;
   wire [11:0] lo2;
   wire [2:0] ki2;
   wire [11:0] per2;
   wire [15:0] thr2;
   wire [5:0] ol2;
   // a write to an unknown channel or code is dropped
   scp_chan u_ch1 (
      .CLK_SYS(CLK_SYS),
      .RST(RST),
      .wr_lim(wr_ok & sel1 & hit_lim),
      .wr_per(wr_ok & sel1 & hit_per),
      .wr_thr(wr_ok & sel1 & hit_thr),
      .wdata(FRAME_DATA),
      .thr_load(THR_LOAD_1),
      .thr_value(THR_VALUE_1),
      .hi_lim_reg(hi1),
      .lo_lim_reg(lo1),
      .ki_idx_reg(ki1),
      .period_reg(per1),
      .thr_reg(thr1),
      .ol_reg(ol1)
   );
   scp_chan u_ch2 (
      .CLK_SYS(CLK_SYS),
      .RST(RST),
      .wr_lim(wr_ok & sel2 & hit_lim),
      .wr_per(wr_ok & sel2 & hit_per),
      .wr_thr(wr_ok & sel2 & hit_thr),
      .wdata(FRAME_DATA),
      .thr_load(THR_LOAD_2),
      .thr_value(THR_VALUE_2),
      .hi_lim_reg(hi2),
      .lo_lim_reg(lo2),
      .ki_idx_reg(ki2),
      .period_reg(per2),
      .thr_reg(thr2),
      .ol_reg(ol2)
   );

   wire tick;
   scp_tick #(.DIV(`SCP_PER_TICKS)) u_tick (
      .CLK_SYS(CLK_SYS),
      .RST(RST),
      .tick(tick)
   );

   // ****************************************
   // read-back
   // ****************************************
   reg [31:0] rd_next;
   reg [11:0] r_hi;
   reg [11:0] r_lo;
   reg [2:0] r_ki;
   reg [11:0] r_per;
   reg [15:0] r_thr;
   reg [5:0] r_ol;
   always @* begin
      r_hi = sel2 ? hi2 : hi1;
      r_lo = sel2 ? lo2 : lo1;
      r_ki = sel2 ? ki2 : ki1;
      r_per = sel2 ? per2 : per1;
      r_thr = sel2 ? thr2 : thr1;
      r_ol = sel2 ? ol2 : ol1;
      rd_next = 32'h00000000;
      rd_next[`SCP_CODE_HI:`SCP_CODE_LO] = code;
      rd_next[`SCP_CH_HI:`SCP_CH_LO] = chan;
      if (!(sel1 | sel2)) begin
         rd_next[`SCP_CH_HI:`SCP_CH_LO] = chan;
      end else if (hit_lim) begin
         rd_next[`SCP_HILIM_HI:`SCP_HILIM_LO] = r_hi;
         rd_next[`SCP_LOLIM_HI:`SCP_LOLIM_LO] = r_lo;
      end else if (hit_per) begin
         rd_next[`SCP_KI_HI:`SCP_KI_LO] = r_ki;
         rd_next[`SCP_PER_HI:`SCP_PER_LO] = r_per;
      end else if (hit_thr) begin
         rd_next[`SCP_THR_HI:`SCP_THR_LO] = r_thr;
         rd_next[`SCP_OL_HI:`SCP_OL_LO] = r_ol;
      end
   end

   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         READ_VALID <= 1'b0;
         READ_DATA <= 32'h00000000;
      end else begin
         READ_VALID <= FRAME_VALID & ~is_write;
         if (FRAME_VALID & ~is_write) begin
            READ_DATA <= rd_next;
         end
      end
   end

   // ****************************************
   // applied values
   // ****************************************
   // clamps are scaled by a shift so the outputs match the integrator width
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         CLAMP_HI_1 <= 18'sh00000;
         CLAMP_LO_1 <= 18'sh00000;
         KI_SHIFT_1 <= 3'h0;
         PERIOD_CLKS_1 <= 16'h0000;
         OL_ON_EN_1 <= 1'b0;
         OL_ON_LIMIT_1 <= 6'h00;
         CLAMP_HI_2 <= 18'sh00000;
         CLAMP_LO_2 <= 18'sh00000;
         KI_SHIFT_2 <= 3'h0;
         PERIOD_CLKS_2 <= 16'h0000;
         OL_ON_EN_2 <= 1'b0;
         OL_ON_LIMIT_2 <= 6'h00;
         PERIOD_TICK <= 1'b0;
      end else begin
         CLAMP_HI_1 <= $signed({1'b0, hi1, 5'h00});
         CLAMP_LO_1 <= -$signed({1'b0, lo1, 5'h00});
         KI_SHIFT_1 <= ki1;
         PERIOD_CLKS_1 <= {per1, 4'h0};
         OL_ON_EN_1 <= (ol1 != 6'h00);
         OL_ON_LIMIT_1 <= ol1;
         CLAMP_HI_2 <= $signed({1'b0, hi2, 5'h00});
         CLAMP_LO_2 <= -$signed({1'b0, lo2, 5'h00});
         KI_SHIFT_2 <= ki2;
         PERIOD_CLKS_2 <= {per2, 4'h0};
         OL_ON_EN_2 <= (ol2 != 6'h00);
         OL_ON_LIMIT_2 <= ol2;
         PERIOD_TICK <= tick;
      end
   end
endmodule // scp_top

// ---- dv/scp_host.sv ----
`timescale 1ns/1ps
// ****
// host frame master
// ****
module scp_host (
   // clock
   input wire logic clk,
   // frame port
   output logic frame_valid,
   output logic [31:0] frame_data
);
   initial begin
      frame_valid = 1'b0;
      frame_data = 32'h0000_0000;
   end
   function automatic logic [31:0] make(input logic rw, input logic [3:0] c,
      input logic [1:0] h, input logic [23:0] f);
      make = {rw, c, 1'b0, h, f};
   endfunction
   // called at a falling edge; frame stands for exactly one cycle
   task automatic send(input logic [31:0] w);
      frame_valid = 1'b1;
      frame_data = w;
      @(negedge clk);
   endtask
   // idle data toggles so a stale frame never looks live
   task automatic idle(input int n);
      repeat (n) begin
         frame_valid = 1'b0;
         frame_data = ~frame_data;
         @(negedge clk);
      end
   endtask
endmodule // scp_host

// ---- dv/scp_chk_assertions.sv ----
`timescale 1ns/1ps
// ****
// parameter register checks
// ****
module scp_chk (
   // clock and reset
   input wire CLK_SYS,
   input wire RST,
   // frame port
   input wire FRAME_VALID,
   input wire [31:0] FRAME_DATA,
   input wire READ_VALID,
   input wire [31:0] READ_DATA,
   // applied, first channel
   input wire signed [17:0] CLAMP_HI_1,
   input wire signed [17:0] CLAMP_LO_1,
   input wire [2:0] KI_SHIFT_1,
   input wire [15:0] PERIOD_CLKS_1,
   input wire OL_ON_EN_1,
   input wire [5:0] OL_ON_LIMIT_1,
   input wire PERIOD_TICK
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_rd;
      FRAME_VALID && !FRAME_DATA[31];
   endsequence
   sequence s_wr(k);
      FRAME_VALID && FRAME_DATA[31:27] == k && FRAME_DATA[25:24] == 2'h1;
   endsequence
   a_read_answer: assert property (s_rd |=> READ_VALID && !READ_DATA[31])
      else $error("read not answered");
   a_no_extra_read: assert property (!(FRAME_VALID && !FRAME_DATA[31]) |=> !READ_VALID)
      else $error("unrequested read answer");
   a_read_echo: assert property (s_rd |=> READ_DATA[30:24] ==
      {$past(FRAME_DATA[30:27]), 1'b0, $past(FRAME_DATA[25:24])}) else $error("bad echo");
   a_limit_apply: assert property (s_wr(5'h14) |-> ##2
      CLAMP_HI_1 == 18'({$past(FRAME_DATA[23:12], 2), 5'h00}) &&
      CLAMP_LO_1 == -18'({$past(FRAME_DATA[11:0], 2), 5'h00})) else $error("bad clamp");
   a_gain_sat: assert property (s_wr(5'h15) |-> ##2 KI_SHIFT_1 ==
      (($past(FRAME_DATA[22:20], 2) == 3'h7) ? 3'h6 : $past(FRAME_DATA[22:20], 2)))
      else $error("bad gain index");
   a_period_apply: assert property (s_wr(5'h15) |-> ##2
      PERIOD_CLKS_1 == {$past(FRAME_DATA[11:0], 2), 4'h0}) else $error("bad period");
   a_ol_limit: assert property (s_wr(5'h16) |-> ##2
      OL_ON_LIMIT_1 == $past(FRAME_DATA[5:0], 2)) else $error("bad open-load limit");
   a_ol_enable: assert property (s_wr(5'h16) |-> ##2
      OL_ON_EN_1 == ($past(FRAME_DATA[5:0], 2) != 6'h00)) else $error("bad open-load enable");
   a_tick_gap: assert property (PERIOD_TICK |=> !PERIOD_TICK [*8] ##1
      !PERIOD_TICK [*7] ##1 PERIOD_TICK) else $error("bad tick spacing");
endmodule // scp_chk
bind scp_top scp_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .FRAME_VALID(FRAME_VALID),
   .FRAME_DATA(FRAME_DATA), .READ_VALID(READ_VALID), .READ_DATA(READ_DATA),
   .CLAMP_HI_1(CLAMP_HI_1), .CLAMP_LO_1(CLAMP_LO_1), .KI_SHIFT_1(KI_SHIFT_1),
   .PERIOD_CLKS_1(PERIOD_CLKS_1), .OL_ON_EN_1(OL_ON_EN_1), .OL_ON_LIMIT_1(OL_ON_LIMIT_1),
   .PERIOD_TICK(PERIOD_TICK));

// ---- dv/tb.sv ----
`timescale 1ns/1ps
// ****
// parameter register bench
// ****
module tb;
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic ld1 = 1'b0;
   logic ld2 = 1'b0;
   logic [15:0] tv1 = 16'h0000;
   logic [15:0] tv2 = 16'h0000;
   wire fv, rv, olen;
   wire [31:0] fd, rdat;
   wire signed [17:0] chi, clo, chi2, clo2;
   wire [2:0] kis, kis2;
   wire [15:0] pc1, pc2;
   wire [5:0] oll1, oll2;
   wire olen2;
   int fail_count = 0;
   int cmp_count = 0;
   logic [31:0] q[$];
   logic [11:0] hi[1:2], lo[1:2], pe[1:2];
   logic [2:0] ki[1:2];
   logic [15:0] th[1:2];
   logic [5:0] ol[1:2];
   always #12.5 CLK_SYS = ~CLK_SYS;
   scp_host host (.clk(CLK_SYS), .frame_valid(fv), .frame_data(fd));
   scp_top DUT (.CLK_SYS(CLK_SYS), .RST(RST), .FRAME_VALID(fv), .FRAME_DATA(fd),
      .READ_VALID(rv), .READ_DATA(rdat), .THR_LOAD_1(ld1), .THR_LOAD_2(ld2),
      .THR_VALUE_1(tv1), .THR_VALUE_2(tv2), .CLAMP_HI_1(chi), .CLAMP_LO_1(clo),
      .KI_SHIFT_1(kis), .PERIOD_CLKS_1(pc1), .OL_ON_EN_1(olen), .OL_ON_LIMIT_1(oll1),
      .CLAMP_HI_2(chi2), .CLAMP_LO_2(clo2), .KI_SHIFT_2(kis2), .PERIOD_CLKS_2(pc2),
      .OL_ON_EN_2(olen2), .OL_ON_LIMIT_2(oll2), .PERIOD_TICK());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // answers are matched oldest first, so a lost or extra answer shows
   always @(posedge CLK_SYS) begin
      if (rv === 1'b1) begin
         if (q.size() == 0) chk(rdat, 32'hFFFF_FFFF);
         else chk(rdat, q.pop_front());
      end
   end
   function automatic logic [23:0] flds(input logic [3:0] c, input logic [1:0] h);
      if (h == 2'h0 || h == 2'h3) return 24'h0;
      case (c)
         4'h4: return {hi[h], lo[h]};
         4'h5: return {1'b0, ki[h], 8'h00, pe[h]};
         4'h6: return {2'b00, th[h], ol[h]};
         default: return 24'h0;
      endcase
   endfunction
   task automatic rd(input logic [3:0] c, input logic [1:0] h);
      q.push_back(host.make(1'b0, c, h, flds(c, h)));
      host.send(host.make(1'b0, c, h, 24'($urandom)));
   endtask
   task automatic wr(input logic [3:0] c, input logic [1:0] h, input logic [23:0] f);
      host.send(host.make(1'b1, c, h, f));
      if (h == 2'h1 || h == 2'h2) begin
         if (c == 4'h4) {hi[h], lo[h]} = f;
         if (c == 4'h5) ki[h] = (f[22:20] == 3'h7) ? 3'h6 : f[22:20];
         if (c == 4'h5) pe[h] = f[11:0];
         if (c == 4'h6) ol[h] = f[5:0];
      end
   endtask
   // applied outputs trail the stored fields, so call this only after idle cycles
   task automatic chk_applied;
      chk({14'h0, chi}, {15'h0, hi[1], 5'h00});
      chk({14'h0, clo}, {14'h0, 18'h00000 - {1'b0, lo[1], 5'h00}});
      chk({6'h0, kis, pc1, olen, oll1},
         {6'h0, ki[1], pe[1], 4'h0, (ol[1] != 6'h00), ol[1]});
      chk({14'h0, chi2}, {15'h0, hi[2], 5'h00});
      chk({14'h0, clo2}, {14'h0, 18'h00000 - {1'b0, lo[2], 5'h00}});
      chk({6'h0, kis2, pc2, olen2, oll2},
         {6'h0, ki[2], pe[2], 4'h0, (ol[2] != 6'h00), ol[2]});
   endtask
   task automatic read_all;
      for (int c = 4; c <= 6; c++) for (int h = 1; h <= 2; h++) rd(4'(c), 2'(h));
      host.idle(3);
      for (int i = 0; i < 40 && q.size() != 0; i++) @(negedge CLK_SYS);
      if (q.size() != 0) begin
         fail_count++;
         finish_test();
      end
   endtask
   task automatic do_reset;
      RST = 1'b1;
      repeat (5) @(negedge CLK_SYS);
      RST = 1'b0;
      hi = '{12'h7FF, 12'h7FF};
      lo = '{12'h7FF, 12'h7FF};
      ki = '{3'h2, 3'h2};
      pe = '{12'h000, 12'h000};
      th = '{16'h0000, 16'h0000};
      ol = '{6'h00, 6'h00};
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(47));
      do_reset();
      read_all();
      chk_applied();
      chk({14'h0, chi}, 32'h0000_FFE0);
      chk({14'h0, clo}, 32'h0003_0020);
      chk({29'h0, kis}, 32'h2);
      $display("test reset values done");
      repeat (24) wr(4'(4 + $urandom_range(2)), 2'($urandom_range(2, 1)), 24'($urandom));
      wr(4'h5, 2'h1, 24'h70_0ABC);
      wr(4'h6, 2'h1, 24'h3F_FFE5);
      host.idle(3);
      chk({29'h0, kis}, 32'h6);
      chk({31'h0, olen}, 32'h1);
      read_all();
      chk_applied();
      $display("test random writes done");
      tv1 = 16'($urandom);
      tv2 = 16'($urandom);
      ld1 = 1'b1;
      ld2 = 1'b1;
      @(negedge CLK_SYS);
      ld1 = 1'b0;
      ld2 = 1'b0;
      th = '{tv1, tv2};
      wr(4'h6, 2'h2, 24'h3F_FFC0);
      read_all();
      chk_applied();
      $display("test threshold load done");
      wr(4'h4, 2'h0, 24'h00_0000);
      wr(4'h4, 2'h3, 24'h00_0000);
      wr(4'h7, 2'h1, 24'hFF_FFFF);
      rd(4'h4, 2'h3);
      rd(4'h7, 2'h1);
      read_all();
      chk_applied();
      $display("test bad channel done");
      do_reset();
      read_all();
      chk_applied();
      $display("test second reset done");
      finish_test();
   end
endmodule // tb
